// file: hw/sal_consts.svh
/*
 Constants for the status, sample and load-control register slice.
 Assumes inclusion by bare name from the design modules and the bench.
*/
`ifndef SAL_CONSTS_SVH
`define SAL_CONSTS_SVH
`define SAL_ADDR_STATUS      10'h00d
`define SAL_ADDR_RAW         10'h00e
`define SAL_ADDR_DEC         10'h00f
`define SAL_ADDR_MODE        10'h010
`define SAL_ADDR_THR         10'h011
`define SAL_ADDR_LOW         10'h012
`define SAL_RST_STATUS       16'h4000
`define SAL_RST_THR          8'h1e
`define SAL_RST_LOW          6'h1e
`define SAL_THR_MIN          8'h01
`define SAL_THR_MAX          8'hfe
`define SAL_LOW_MIN          6'h01
`define SAL_BIT_READY        14
`define SAL_BIT_BUSY         13
`define SAL_BIT_COOL         11
`define SAL_BIT_THERM        10
`define SAL_BIT_LINK         9
`define SAL_BIT_MEM          8
`define SAL_BIT_WARNC        3
`define SAL_BIT_WARNB        2
`define SAL_BIT_WARNA        1
`define SAL_BIT_DOUT         0
`define SAL_CLK_HZ           250000000
`define SAL_SAMPLE_HZ        100000
`define SAL_SAMPLE_CYCLES    (`SAL_CLK_HZ / `SAL_SAMPLE_HZ)
`endif

// file: hw/sal_pkg.sv
/*
 Types shared by the register slice modules.
 Assumes sal_consts.svh is on the include path.
*/
package sal_pkg;
    typedef enum logic [1:0] {SAL_LOAD_OFF, SAL_LOAD_LOW, SAL_LOAD_HIGH} sal_load_t;
    typedef struct packed {
        logic [11:0] cnt;
        logic        tick;
    } sal_tick_state_t;
endpackage

// file: hw/sal_tick.sv
/*
 Sample-rate enable divider: one-cycle pulse every sample period.
 Assumes a single system clock and synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "sal_consts.svh"
module sal_tick
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output logic      tick
);
    localparam logic [11:0] LAST = 12'(`SAL_SAMPLE_CYCLES - 1);

    sal_pkg::sal_tick_state_t st;
    sal_pkg::sal_tick_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.tick = 1'b0;
        if (st.cnt == LAST)
        begin
            next_st.cnt  = 12'h000;
            next_st.tick = 1'b1;
        end
        else
        begin
            next_st.cnt = st.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign tick = st.tick;
endmodule

// file: hw/sal_regs.sv
/*
 Status word, ADC sample registers and programmable-load mode selection.
 Assumes the serial port front end delivers decoded single-cycle reads and
 writes of 16-bit words, and that condition and ADC inputs are synchronous.
*/
`timescale 1ns/10ps
`include "sal_consts.svh"
module sal_regs
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [9:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic [15:0]      reg_rdata,
    input  wire logic [7:0]  adc_code,
    input  wire logic [3:0]  decimation_rate_field,
    input  wire logic        comm_busy,
    input  wire logic        channel_cooling_flag,
    input  wire logic        thermal_shutdown_flag,
    input  wire logic        link_fault_flag,
    input  wire logic        register_mismatch_flag,
    input  wire logic        warning_a_flag,
    input  wire logic        warning_b_flag,
    input  wire logic        warning_c_flag,
    input  wire logic        digital_output_state,
    output logic [1:0]       load_select,
    output logic [5:0]       low_current_code,
    output logic             load_idle_mode
);
    typedef struct packed {
        logic [15:0] status;
        logic [7:0]  raw;
        logic [7:0]  dec;
        logic [15:0] dec_cnt;
        logic        mode;
        logic [7:0]  thr;
        logic [5:0]  low;
        logic [1:0]  sel;
        logic [15:0] rdata;
        logic        ready;
    } sal_state_t;

    sal_state_t st;
    sal_state_t next_st;
    logic       tick;
    logic [15:0] dec_period;

    sal_tick u_tick
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    // A rate field of N keeps one sample in 2^N.
    assign dec_period = 16'h0001 << decimation_rate_field;

    always_comb
    begin
        next_st = st;
        next_st.ready = 1'b1;
        // Live status, rebuilt every cycle so a poll sees present state.
        next_st.status = 16'h0000;
        next_st.status[`SAL_BIT_READY] = st.ready;
        next_st.status[`SAL_BIT_BUSY]  = comm_busy;
        next_st.status[`SAL_BIT_COOL]  = channel_cooling_flag;
        next_st.status[`SAL_BIT_THERM] = thermal_shutdown_flag;
        next_st.status[`SAL_BIT_LINK]  = link_fault_flag;
        next_st.status[`SAL_BIT_MEM]   = register_mismatch_flag;
        next_st.status[`SAL_BIT_WARNC] = warning_c_flag;
        next_st.status[`SAL_BIT_WARNB] = warning_b_flag;
        next_st.status[`SAL_BIT_WARNA] = warning_a_flag;
        next_st.status[`SAL_BIT_DOUT]  = digital_output_state;

        if (tick)
        begin
            next_st.raw = adc_code;
            if (st.dec_cnt + 16'h0001 >= dec_period)
            begin
                next_st.dec_cnt = 16'h0000;
                next_st.dec     = adc_code;
            end
            else
            begin
                next_st.dec_cnt = st.dec_cnt + 16'h0001;
            end
            // Selection follows the fresh sample with the current settings.
            if (adc_code == 8'h00)
            begin
                next_st.sel = sal_pkg::SAL_LOAD_OFF;
            end
            else if (st.mode)
            begin
                next_st.sel = sal_pkg::SAL_LOAD_HIGH;
            end
            else if (adc_code > st.thr)
            begin
                next_st.sel = sal_pkg::SAL_LOAD_HIGH;
            end
            else
            begin
                next_st.sel = sal_pkg::SAL_LOAD_LOW;
            end
        end

        if (reg_wr)
        begin
            case (reg_addr)
                `SAL_ADDR_MODE: next_st.mode = reg_wdata[0];
                `SAL_ADDR_THR:
                begin
                    if (reg_wdata[7:0] < `SAL_THR_MIN)
                    begin
                        next_st.thr = `SAL_THR_MIN;
                    end
                    else if (reg_wdata[7:0] > `SAL_THR_MAX)
                    begin
                        next_st.thr = `SAL_THR_MAX;
                    end
                    else
                    begin
                        next_st.thr = reg_wdata[7:0];
                    end
                end
                `SAL_ADDR_LOW:
                begin
                    if (reg_wdata[5:0] == 6'h00)
                    begin
                        next_st.low = `SAL_LOW_MIN;
                    end
                    else
                    begin
                        next_st.low = reg_wdata[5:0];
                    end
                end
                default: next_st.low = next_st.low;
            endcase
        end

        if (reg_rd)
        begin
            case (reg_addr)
                `SAL_ADDR_STATUS: next_st.rdata = st.status;
                `SAL_ADDR_RAW:    next_st.rdata = {8'h00, st.raw};
                `SAL_ADDR_DEC:    next_st.rdata = {8'h00, st.dec};
                `SAL_ADDR_MODE:   next_st.rdata = {15'h0000, st.mode};
                `SAL_ADDR_THR:    next_st.rdata = {8'h00, st.thr};
                `SAL_ADDR_LOW:    next_st.rdata = {10'h000, st.low};
                default:          next_st.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            st        <= '0;
            st.status <= `SAL_RST_STATUS;
            st.thr    <= `SAL_RST_THR;
            st.low    <= `SAL_RST_LOW;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata        = st.rdata;
    assign load_select      = st.sel;
    assign low_current_code = st.low;
    assign load_idle_mode   = st.mode;

    thr_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        st.thr >= 8'h01 && st.thr <= 8'hfe)
        else $error("threshold out of range");
    thr_clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == 10'h011 && reg_wdata[7:0] == 8'hff |=> st.thr == 8'hfe)
        else $error("threshold not clamped high");
    low_min_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == 10'h012 && reg_wdata[5:0] == 6'h00 |=> st.low == 6'h01)
        else $error("low code zero not mapped");
    status_live_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        ##1 st.status[10] == $past(thermal_shutdown_flag) && st.status[15] == 1'b0
        && st.status[7:4] == 4'h0)
        else $error("status not live");
    ready_bit_a: assert property (@(posedge clk_sys) $rose(rst_n) |-> ##2 st.status[14])
        else $error("ready bit missing");
    high_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick && st.mode && adc_code != 8'h00 && !reg_wr |=> st.sel == sal_pkg::SAL_LOAD_HIGH)
        else $error("high idle wrong");
    low_above_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick && !st.mode && adc_code > st.thr |=> st.sel == sal_pkg::SAL_LOAD_HIGH)
        else $error("low idle above threshold wrong");
    low_below_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick && !st.mode && adc_code != 8'h00 && adc_code <= st.thr
        |=> st.sel == sal_pkg::SAL_LOAD_LOW)
        else $error("low idle below threshold wrong");
    zero_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick && adc_code == 8'h00 |=> st.sel == sal_pkg::SAL_LOAD_OFF)
        else $error("zero code not off");
    raw_update_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        tick |=> st.raw == $past(adc_code))
        else $error("raw sample stale");
endmodule

// file: bench/sal_host.sv
/*
 Host model for the register slice: one-cycle read and write strobes.
 Assumes the bench calls its tasks from one process only.
*/
`timescale 1ns/10ps
module sal_host
(
    input  wire logic        clk_sys,
    input  wire logic [15:0] reg_rdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [9:0]       reg_addr,
    output logic [15:0]      reg_wdata
);
    initial
    begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 10'h000;
        reg_wdata = 16'h0000;
    end
    // A released bus shows the inverse so a stale address never looks valid.
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [9:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
endmodule

// file: bench/status_adc_load_control_tb_top.sv
/*
 Self-checking bench for the register slice.
 Assumes sal_regs and sal_host are compiled first.
*/
`timescale 1ns/10ps
`include "sal_consts.svh"
module status_adc_load_control_tb_top;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [8:0]  cond = 9'h000;
    logic [7:0]  adc_code = 8'h00;
    logic [3:0]  dec_rate = 4'h0;
    logic        reg_wr;
    logic        reg_rd;
    logic [9:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic [1:0]  load_select;
    logic [5:0]  low_current_code;
    logic        load_idle_mode;
    int          err_total = 0;
    int          checks = 0;
    int          cycles = 0;
    int          pos [9] = '{13, 11, 10, 9, 8, 3, 2, 1, 0};
    logic        tmode [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0]  tcode [6] = '{8'h7f, 8'h80, 8'h81, 8'h00, 8'h01, 8'h00};
    // Expected selection in enum order: off, low, high.
    logic [1:0]  tsel [6] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h2, 2'h0};
    always #2 clk_sys = ~clk_sys;
    sal_host host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    sal_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .adc_code(adc_code), .decimation_rate_field(dec_rate), .comm_busy(cond[0]),
        .channel_cooling_flag(cond[1]), .thermal_shutdown_flag(cond[2]),
        .link_fault_flag(cond[3]), .register_mismatch_flag(cond[4]),
        .warning_c_flag(cond[5]), .warning_b_flag(cond[6]), .warning_a_flag(cond[7]),
        .digital_output_state(cond[8]), .load_select(load_select),
        .low_current_code(low_current_code), .load_idle_mode(load_idle_mode));
    task automatic results();
        if (err_total == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            err_total++;
        end
    endtask
    task automatic rc(input logic [9:0] a, input logic [15:0] e, input string n);
        logic [15:0] d;
        host.rd(a, d);
        chk(n, e, d);
    endtask
    always @(posedge clk_sys)
    begin
        cycles++;
        // Tests need about 22500 cycles; the ceiling leaves ample margin.
        if (cycles == 40000)
        begin
            err_total++;
            results();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rc(`SAL_ADDR_STATUS, 16'h4000, "status");
        rc(`SAL_ADDR_THR, 16'h001e, "threshold");
        rc(`SAL_ADDR_MODE, 16'h0000, "mode");
        rc(`SAL_ADDR_RAW, 16'h0000, "raw");
        rc(`SAL_ADDR_DEC, 16'h0000, "decimated");
        for (int i = 0; i < 9; i++)
        begin
            @(posedge clk_sys) cond <= 9'h001 << i;
            repeat (2) @(posedge clk_sys);
            rc(`SAL_ADDR_STATUS, 16'h4000 | (16'h0001 << pos[i]), "status");
        end
        @(posedge clk_sys) cond <= 9'h000;
        repeat (2) @(posedge clk_sys);
        rc(`SAL_ADDR_STATUS, 16'h4000, "status");
        host.wr(`SAL_ADDR_STATUS, 16'h0000);
        rc(`SAL_ADDR_STATUS, 16'h4000, "status");
        rc(10'h020, 16'h0000, "unmapped");
        host.wr(`SAL_ADDR_THR, 16'h0000);
        rc(`SAL_ADDR_THR, 16'h0001, "threshold");
        host.wr(`SAL_ADDR_THR, 16'hffff);
        rc(`SAL_ADDR_THR, 16'h00fe, "threshold");
        host.wr(`SAL_ADDR_THR, 16'h0080);
        rc(`SAL_ADDR_THR, 16'h0080, "threshold");
        host.wr(`SAL_ADDR_MODE, 16'hffff);
        rc(`SAL_ADDR_MODE, 16'h0001, "mode");
        chk("idle_mode", 16'h0001, {15'h0000, load_idle_mode});
        host.wr(`SAL_ADDR_LOW, 16'h0000);
        @(posedge clk_sys);
        chk("low_code", 16'h0001, {10'h000, low_current_code});
        host.wr(`SAL_ADDR_LOW, 16'h0025);
        @(posedge clk_sys);
        chk("low_code", 16'h0025, {10'h000, low_current_code});
        for (int j = 0; j < 6; j++)
        begin
            host.wr(`SAL_ADDR_MODE, {15'h0000, tmode[j]});
            @(posedge clk_sys) adc_code <= tcode[j];
            repeat (2600) @(posedge clk_sys);
            chk("load_select", {14'h0, tsel[j]}, {14'h0, load_select});
            rc(`SAL_ADDR_RAW, {8'h00, tcode[j]}, "raw");
            rc(`SAL_ADDR_DEC, {8'h00, tcode[j]}, "decimated");
        end
        // Align to a sample edge so that a rate of one in two has a known phase.
        @(posedge clk_sys iff dut.u_tick.tick);
        dec_rate <= 4'h1;
        adc_code <= 8'h5a;
        @(posedge clk_sys iff dut.u_tick.tick);
        rc(`SAL_ADDR_RAW, 16'h005a, "raw");
        rc(`SAL_ADDR_DEC, 16'h0000, "decimated");
        @(posedge clk_sys iff dut.u_tick.tick);
        rc(`SAL_ADDR_DEC, 16'h005a, "decimated");
        results();
    end
endmodule
